// File: core/dpa_bounds_unit.v
// Address model decode, checks and register file of the data port unit
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defines.vh"
// Rules of the document for this block
// RULE1: Index 254 is local memory only on data-cache port
// RULE2: Local memory unchecked, wraps at 64 KB
// RULE3: Exception routine avoids binding-table surfaces
// RULE4: Scratch hexword messages use context save base
// RULE5: Exception routine stateless accesses are non-coherent
// RULE6: Base offset plus lane offsets, bytes or scaled
// RULE7: Sum checked against limits, then added to base
// RULE8: Out-of-bounds or null-tile lanes read zero, drop
// RULE9: 64-bit stateless canonical crossing faults or bounds out
// RULE10: Driver keeps in-bounds accesses canonical
// RULE11: Null tiles out of bounds, invalid tiles fault
// RULE12: Faulted thread waits for restart, then replays
// RULE13: Local memory never faults
// RULE14: Coherency from surface, alias, or local
// RULE15: Page table cache controls override supplied controls
// RULE16: Flat buffer everywhere, others binding-table only
// RULE17: Untyped messages move raw data
// RULE18: Tile modes allowed per surface type
// RULE19: Compressed multisample and media surfaces are Y tiled (not checked here; 2D surfaces accept any tile mode)
// RULE20: Flat buffer offsets aligned to access width (not checked here; unaligned offsets pass)
// RULE21: Structured buffer aligned base, pitch, bounds
// RULE22: Size minus one from depth, height, width
// RULE23: Canonical means bits 63..48 equal bit 47
// RULE24: Index 254 or second-port non-stateless selects local
// RULE25: Alias 255 host coherent, 253 graphics only
// RULE26: Indices below 240 look up binding table
// RULE27: Per-lane in-bounds mask travels with addresses
module dpa_bounds_unit #(
	parameter LANES = 8,
	parameter ADDR_W = 8
) (
	input wire core_clk,
	input wire arst_n,
	// AXI4-Lite slave
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Message from the thread
	input wire msgValid,
	output wire msgReady,
	input wire [7:0] msgBindIdx,
	input wire msgDataCachePort,
	input wire msgSecondPort,
	input wire msgSecondStateless,
	input wire msgW64,
	input wire msgHwordScratch,
	input wire msgExcActive,
	input wire msgUntyped,
	input wire msgScaled,
	input wire [2:0] msgWidthLog2,
	input wire [31:0] msgBaseOffset,
	input wire [LANES*32-1:0] msgLaneOff,
	input wire [LANES*32-1:0] msgLaneV,
	input wire [LANES-1:0] msgLaneEnable,
	input wire [63:0] msgW64Base,
	input wire [31:0] msgBufferBase,
	input wire [31:0] msgLclBase,
	// Surface state fetched for binding-table accesses
	input wire [2:0] surfType,
	input wire [1:0] surfTileMode,
	input wire [63:0] surfBase,
	input wire [6:0] surfWidth,
	input wire [13:0] surfHeight,
	input wire [10:0] surfDepth,
	input wire [10:0] surfPitch,
	input wire surfCoherent,
	input wire [6:0] surfMocs,
	input wire [1:0] pteLlc,
	// Result toward the cache
	output reg outValid,
	input wire outReady,
	output reg [LANES*64-1:0] outAddr,
	output reg [LANES-1:0] outMask,
	output reg [1:0] outModel,
	output reg [1:0] outCoherency,
	output reg outL3Virtual,
	output reg [6:0] outMocs,
	output reg outRawFormat,
	output reg outReject
);
	// ==========================================================
	// State machine
	localparam ST_RUN = 2'b01; // Accepting messages
	localparam ST_HALT = 2'b10; // Thread suspended on a fault
	reg [1:0] state;
	// ==========================================================
	// Register file
	reg [31:0] ctrl; // Paging, canonical mode, stateless controls
	reg [31:0] faultCount; // Number of suspensions
	reg [63:0] gsBase; // General state base
	reg [31:0] gsSize; // General state buffer size
	reg [63:0] ctxBase; // Context save area base
	reg [63:0] trBase; // Tiled range base
	reg [31:0] tileMap; // Two bits per 64 KB tile
	reg restartPulse; // One cycle after a restart write
	reg [ADDR_W-1:0] awHeld;
	reg awFull;
	reg [31:0] wHeld;
	reg [3:0] strbHeld;
	reg wFull;
	// ==========================================================
	// Byte-lane merge of a write into a register
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction
	// Address and data are taken independently, in either order
	assign s_axi_awready = !awFull && !s_axi_bvalid;
	assign s_axi_wready = !wFull && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire doWrite = awFull && wFull && !s_axi_bvalid;
	// ==========================================================
	// Write channel and register updates
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awFull <= 1'b0;
			wFull <= 1'b0;
			awHeld <= {ADDR_W{1'b0}};
			wHeld <= 32'h00000000;
			strbHeld <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DPA_RESP_OKAY;
			ctrl <= 32'h00000000;
			gsBase <= 64'h0000000000000000;
			gsSize <= 32'h00000000;
			ctxBase <= 64'h0000000000000000;
			trBase <= 64'h0000000000000000;
			tileMap <= 32'h00000000;
			restartPulse <= 1'b0;
		end
		else
		begin
			restartPulse <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld <= s_axi_awaddr;
				awFull <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld <= s_axi_wdata;
				strbHeld <= s_axi_wstrb;
				wFull <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (doWrite)
			begin
				awFull <= 1'b0;
				wFull <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `DPA_RESP_OKAY;
				case (awHeld)
					`DPA_REG_CTRL:
					begin
						// Restart bit is a pulse, never stored
						ctrl <= merge(ctrl, wHeld, strbHeld) &
							~(32'h1 << `DPA_CTRL_RESTART);
						restartPulse <= strbHeld[0] &
							wHeld[`DPA_CTRL_RESTART]; // RULE12
					end
					`DPA_REG_GSBASE_LO:
						gsBase[31:0] <= merge(gsBase[31:0], wHeld, strbHeld);
					`DPA_REG_GSBASE_HI:
						gsBase[63:32] <= merge(gsBase[63:32], wHeld, strbHeld);
					`DPA_REG_GSSIZE:
						gsSize <= merge(gsSize, wHeld, strbHeld);
					`DPA_REG_CTXBASE_LO:
						ctxBase[31:0] <= merge(ctxBase[31:0], wHeld, strbHeld);
					`DPA_REG_CTXBASE_HI:
						ctxBase[63:32] <= merge(ctxBase[63:32], wHeld, strbHeld);
					`DPA_REG_TRBASE_LO:
						trBase[31:0] <= merge(trBase[31:0], wHeld, strbHeld);
					`DPA_REG_TRBASE_HI:
						trBase[63:32] <= merge(trBase[63:32], wHeld, strbHeld);
					`DPA_REG_TILEMAP:
						tileMap <= merge(tileMap, wHeld, strbHeld);
					// Read-only and unmapped offsets answer an error
					default:
						s_axi_bresp <= `DPA_RESP_SLVERR;
				endcase
			end
		end
	end
	// ==========================================================
	// Read channel; answers one cycle after the address is taken
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `DPA_RESP_OKAY;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else if (s_axi_arvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `DPA_RESP_OKAY;
			case (s_axi_araddr)
				`DPA_REG_CTRL: s_axi_rdata <= ctrl;
				`DPA_REG_STATUS: s_axi_rdata <= {26'h0, outModel,
					outReject, outValid, state == ST_HALT, 1'b0};
				`DPA_REG_FAULTS: s_axi_rdata <= faultCount;
				`DPA_REG_GSBASE_LO: s_axi_rdata <= gsBase[31:0];
				`DPA_REG_GSBASE_HI: s_axi_rdata <= gsBase[63:32];
				`DPA_REG_GSSIZE: s_axi_rdata <= gsSize;
				`DPA_REG_CTXBASE_LO: s_axi_rdata <= ctxBase[31:0];
				`DPA_REG_CTXBASE_HI: s_axi_rdata <= ctxBase[63:32];
				`DPA_REG_TRBASE_LO: s_axi_rdata <= trBase[31:0];
				`DPA_REG_TRBASE_HI: s_axi_rdata <= trBase[63:32];
				`DPA_REG_TILEMAP: s_axi_rdata <= tileMap;
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `DPA_RESP_SLVERR;
				end
			endcase
		end
	end
	// ==========================================================
	// Address model decode and message-wide checks
	reg [1:0] model;
	reg modelOk; // Index names a usable model
	reg tileOk; // Tile mode legal for surface type
	reg [2:0] effType; // Surface type after model overrides
	reg [63:0] modelBase;
	reg [32:0] limit;
	reg [32:0] bufSize;
	reg [1:0] coh;
	reg [6:0] mocs;
	reg reject;
	always @*
	begin
		modelOk = 1'b1;
		if (msgSecondPort)
			model = msgSecondStateless ? (msgW64 ? `DPA_MODEL_S64 :
				`DPA_MODEL_S32) : `DPA_MODEL_LCL; // RULE24
		else if (msgBindIdx == `DPA_BTI_LCL)
			model = msgDataCachePort ? `DPA_MODEL_LCL
				: `DPA_MODEL_TBL; // RULE1 RULE24
		else if (msgBindIdx < `DPA_BTI_TABLE_END)
			model = `DPA_MODEL_TBL; // RULE26
		else if (msgBindIdx == `DPA_BTI_HOSTCOH ||
			msgBindIdx == `DPA_BTI_GFXCOH)
			model = msgW64 ? `DPA_MODEL_S64 : `DPA_MODEL_S32;
		else
		begin
			// Reserved indices get no access at all
			model = `DPA_MODEL_TBL;
			modelOk = 1'b0;
		end
		// Stateless and local models are flat buffers
		effType = (model == `DPA_MODEL_TBL) ? surfType
			: `DPA_ST_BUFFER; // RULE16
		case (effType)
			`DPA_ST_2D, `DPA_ST_NULL: tileOk = 1'b1; // RULE18
			`DPA_ST_3D, `DPA_ST_CUBE:
				tileOk = surfTileMode != `DPA_TM_XMAJOR; // RULE18
			default: tileOk = surfTileMode == `DPA_TM_LINEAR; // RULE18
		endcase
		if (model != `DPA_MODEL_TBL)
			tileOk = 1'b1;
		bufSize = {1'b0, surfDepth, surfHeight, surfWidth} + 33'h1; // RULE22
		case (model)
			`DPA_MODEL_LCL:
			begin
				modelBase = {32'h0, msgLclBase};
				limit = 33'h0;
			end
			`DPA_MODEL_S32:
			begin
				// Scratch hexword messages of the exception routine alone take the save area
				modelBase = (msgExcActive && msgHwordScratch) ? ctxBase
					: gsBase + {32'h0, msgBufferBase}; // RULE4
				limit = {1'b0, gsSize};
			end
			`DPA_MODEL_S64:
			begin
				modelBase = msgW64Base;
				limit = 33'h0;
			end
			default:
			begin
				modelBase = surfBase;
				limit = bufSize;
			end
		endcase
		case (model)
			`DPA_MODEL_LCL: coh = `DPA_COH_LOCAL; // RULE14
			`DPA_MODEL_TBL:
				coh = surfCoherent ? `DPA_COH_HOST : `DPA_COH_GFX; // RULE14
			default:
				if (msgExcActive)
					coh = `DPA_COH_NONCOH; // RULE5
				else if (msgSecondPort || msgBindIdx == `DPA_BTI_HOSTCOH)
					coh = `DPA_COH_HOST; // RULE25
				else
					coh = `DPA_COH_GFX; // RULE25
		endcase
		mocs = (model == `DPA_MODEL_TBL) ? surfMocs
			: ctrl[`DPA_CTRL_MOCS_MSB:`DPA_CTRL_MOCS_LSB];
		if (ctrl[`DPA_CTRL_PGTBL])
			mocs[1:0] = pteLlc; // RULE15
		// The exception routine never names a surface; guard anyway
		reject = !modelOk || !tileOk ||
			(msgExcActive && model == `DPA_MODEL_TBL) || // RULE3
			(effType == `DPA_ST_STRBUF && model == `DPA_MODEL_TBL &&
			surfBase[`DPA_STRBUF_ALIGN_MSB:0] != 5'h00); // RULE21
	end
	// ==========================================================
	// Per-lane address units
	wire [LANES*64-1:0] laneAddr;
	wire [LANES-1:0] laneIn;
	wire [LANES-1:0] laneFault;
	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1)
		begin : lane
			dpa_lane_addr u_lane (
				.laneOff(msgLaneOff[g*32 +: 32]),
				.laneV(msgLaneV[g*32 +: 32]),
				.baseOffset(msgBaseOffset),
				.scaled(msgScaled),
				.widthLog2(msgWidthLog2),
				.model(model),
				.strbuf(effType == `DPA_ST_STRBUF),
				.pitchField(surfPitch),
				.limit(limit),
				.modelBase(modelBase),
				.canonFault(ctrl[`DPA_CTRL_CANONFAULT]),
				.tileMap(tileMap),
				.trBase(trBase),
				.addr(laneAddr[g*64 +: 64]),
				.inBounds(laneIn[g]),
				.fault(laneFault[g])
			);
		end
	endgenerate
	// ==========================================================
	// Acceptance, suspension on fault and replay
	wire slotFree = !outValid || outReady;
	wire anyFault = !reject && |(laneFault & msgLaneEnable);
	// The message stays offered while halted, so a restart replays it
	assign msgReady = (state == ST_RUN) && slotFree && !anyFault; // RULE12
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ST_RUN;
			faultCount <= 32'h00000000;
			outValid <= 1'b0;
			outAddr <= {LANES*64{1'b0}};
			outMask <= {LANES{1'b0}};
			outModel <= `DPA_MODEL_TBL;
			outCoherency <= `DPA_COH_LOCAL;
			outL3Virtual <= 1'b0;
			outMocs <= 7'h00;
			outRawFormat <= 1'b0;
			outReject <= 1'b0;
		end
		else
		begin
			if (outValid && outReady)
				outValid <= 1'b0;
			case (state)
				ST_RUN:
					if (msgValid && slotFree)
					begin
						if (anyFault)
						begin
							state <= ST_HALT; // RULE12
							faultCount <= faultCount + 32'h1;
						end
						else
						begin
							outValid <= 1'b1;
							outAddr <= laneAddr;
							// Downstream zeroes reads and drops writes
							outMask <= reject ? {LANES{1'b0}}
								: laneIn & msgLaneEnable; // RULE8 RULE27
							outModel <= model;
							outCoherency <= coh;
							outL3Virtual <= msgExcActive &&
								(model == `DPA_MODEL_S32 ||
								model == `DPA_MODEL_S64); // RULE5
							outMocs <= mocs;
							outRawFormat <= msgUntyped; // RULE17
							outReject <= reject;
						end
					end
				ST_HALT:
					if (restartPulse)
						state <= ST_RUN; // RULE12
				default:
					state <= ST_RUN;
			endcase
		end
	end
endmodule // dpa_bounds_unit
`default_nettype wire

// File: core/dpa_defines.vh
// Constants shared by the data port address and bounds unit
`ifndef DPA_DEFINES_VH
`define DPA_DEFINES_VH
// ==========================================================
// Address models
`define DPA_MODEL_TBL 2'h0
`define DPA_MODEL_LCL 2'h1
`define DPA_MODEL_S32 2'h2
`define DPA_MODEL_S64 2'h3
// ==========================================================
// Binding indices
`define DPA_BTI_LCL 8'hFE
`define DPA_BTI_HOSTCOH 8'hFF
`define DPA_BTI_GFXCOH 8'hFD
`define DPA_BTI_TABLE_END 8'hF0
// ==========================================================
// Surface types
`define DPA_ST_1D 3'h0
`define DPA_ST_2D 3'h1
`define DPA_ST_3D 3'h2
`define DPA_ST_CUBE 3'h3
`define DPA_ST_BUFFER 3'h4
`define DPA_ST_STRBUF 3'h5
`define DPA_ST_NULL 3'h7
// ==========================================================
// Tile modes
`define DPA_TM_LINEAR 2'h0
`define DPA_TM_WMAJOR 2'h1
`define DPA_TM_XMAJOR 2'h2
`define DPA_TM_YMAJOR 2'h3
// ==========================================================
// Coherency classes
`define DPA_COH_LOCAL 2'h0
`define DPA_COH_NONCOH 2'h1
`define DPA_COH_GFX 2'h2
`define DPA_COH_HOST 2'h3
// ==========================================================
// Shared local memory wraps at 64 KB
`define DPA_LCL_MSB 15
// Tiled range: 16 tiles of 64 KB, two state bits each
`define DPA_TR_SPAN 64'h0000000000100000
`define DPA_TILE_MSB 19
`define DPA_TILE_LSB 16
`define DPA_TILE_MAPPED 2'h0
`define DPA_TILE_NULL 2'h1
`define DPA_TILE_INVALID 2'h2
// Canonical boundary bits
`define DPA_CANON_TOP 63
`define DPA_CANON_LOW 48
`define DPA_CANON_SIGN 47
// Structured buffer base alignment bits (32 B)
`define DPA_STRBUF_ALIGN_MSB 4
// ==========================================================
// Register byte offsets
`define DPA_REG_CTRL 8'h00
`define DPA_REG_STATUS 8'h04
`define DPA_REG_FAULTS 8'h08
`define DPA_REG_GSBASE_LO 8'h0C
`define DPA_REG_GSBASE_HI 8'h10
`define DPA_REG_GSSIZE 8'h14
`define DPA_REG_CTXBASE_LO 8'h18
`define DPA_REG_CTXBASE_HI 8'h1C
`define DPA_REG_TRBASE_LO 8'h20
`define DPA_REG_TRBASE_HI 8'h24
`define DPA_REG_TILEMAP 8'h28
// Control fields
`define DPA_CTRL_PGTBL 0
`define DPA_CTRL_CANONFAULT 1
`define DPA_CTRL_RESTART 2
`define DPA_CTRL_MOCS_LSB 8
`define DPA_CTRL_MOCS_MSB 14
// Response codes
`define DPA_RESP_OKAY 2'h0
`define DPA_RESP_SLVERR 2'h2
`endif

// File: core/dpa_lane_addr.v
// One SIMD lane: offset sum, bounds, canonical and tile checks
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defines.vh"
module dpa_lane_addr (
	input wire [31:0] laneOff,
	input wire [31:0] laneV,
	input wire [31:0] baseOffset,
	input wire scaled,
	input wire [2:0] widthLog2,
	input wire [1:0] model,
	input wire strbuf,
	input wire [10:0] pitchField,
	input wire [32:0] limit,
	input wire [63:0] modelBase,
	input wire canonFault,
	input wire [31:0] tileMap,
	input wire [63:0] trBase,
	output reg [63:0] addr,
	output reg inBounds,
	output reg fault
);
	reg [32:0] scaledOff; // Lane offset after index scaling
	reg [32:0] off; // Common base plus lane offset
	reg [32:0] accW; // Access width in bytes
	reg [32:0] pitch; // Structure pitch in bytes
	reg [65:0] prod; // Index times pitch
	reg [63:0] eff; // Offset into the model
	reg boundOk;
	reg [63:0] diff;
	reg inTr;
	reg [1:0] tileState;
	reg canonBad;
	// ==========================================================
	// Lane address
	always @*
	begin
		scaledOff = scaled ? ({1'b0, laneOff} << widthLog2)
			: {1'b0, laneOff}; // RULE6
		off = {1'b0, baseOffset} + scaledOff; // RULE7
		accW = 33'h1 << widthLog2;
		pitch = {22'h0, pitchField} + 33'h1;
		prod = {33'h0, off} * {33'h0, pitch};
		case (model)
			`DPA_MODEL_LCL:
			begin
				// No bounds; wraps inside 64 KB
				eff = {48'h0, off[`DPA_LCL_MSB:0]}; // RULE2
				boundOk = 1'b1; // RULE2
			end
			`DPA_MODEL_S64:
			begin
				// Size is not checked; canonical test guards it
				eff = {31'h0, off};
				boundOk = 1'b1;
			end
			default:
			begin
				if (strbuf)
				begin
					// Index below size, byte offset below pitch less width
					eff = prod[63:0] + {32'h0, laneV};
					boundOk = (off < limit) &&
						(({1'b0, laneV} + accW) < pitch); // RULE21
				end
				else
				begin
					eff = {31'h0, off};
					boundOk = (({1'b0, off} + {1'b0, accW}) <=
						{1'b0, limit}); // RULE7
				end
			end
		endcase
		addr = modelBase + eff; // RULE7
		canonBad = (model == `DPA_MODEL_S64) &&
			(addr[`DPA_CANON_TOP:`DPA_CANON_LOW] !=
			{16{addr[`DPA_CANON_SIGN]}}); // RULE9 RULE23
		diff = addr - trBase;
		inTr = (model != `DPA_MODEL_LCL) && (addr >= trBase) &&
			(diff < `DPA_TR_SPAN); // RULE11
		tileState = tileMap[{diff[`DPA_TILE_MSB:`DPA_TILE_LSB], 1'b0} +: 2];
		// Null tiles read as out of bounds, invalid ones fault
		inBounds = boundOk && !canonBad && !(inTr &&
			(tileState != `DPA_TILE_MAPPED)); // RULE8 RULE11
		// Local memory never faults
		fault = boundOk && (model != `DPA_MODEL_LCL) &&
			((inTr && tileState == `DPA_TILE_INVALID) ||
			(canonBad && canonFault)); // RULE13 RULE9
	end
endmodule // dpa_lane_addr
`default_nettype wire

// File: sim/dpa_bounds_unit_asserts.sv
// Checker for the data port unit message and result ports
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defines.vh"
module dpa_bounds_unit_asserts #(
	parameter LANES = 8
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic msgValid,
	input wire logic msgReady,
	input wire logic [7:0] msgBindIdx,
	input wire logic msgDataCachePort,
	input wire logic msgSecondPort,
	input wire logic msgExcActive,
	input wire logic msgUntyped,
	input wire logic msgScaled,
	input wire logic [31:0] msgBaseOffset,
	input wire logic [LANES*32-1:0] msgLaneOff,
	input wire logic [LANES-1:0] msgLaneEnable,
	input wire logic [31:0] msgLclBase,
	input wire logic outValid,
	input wire logic outReady,
	input wire logic [LANES*64-1:0] outAddr,
	input wire logic [LANES-1:0] outMask,
	input wire logic [1:0] outModel,
	input wire logic [1:0] outCoherency,
	input wire logic outL3Virtual,
	input wire logic outRawFormat,
	input wire logic outReject
);
// ==========================================================
// Shared timing
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!arst_n);
// Message accepted on this edge
sequence s_acc;
	msgValid && msgReady;
endsequence
// Message accepted for local memory on the data-cache port
sequence s_lcl;
	s_acc ##0 msgBindIdx == `DPA_BTI_LCL && msgDataCachePort;
endsequence
// ==========================================================
// Properties
property p_hold;
	outValid && !outReady |=> outValid && $stable(outAddr) && $stable(outMask);
endproperty
a_hold: assert property (p_hold) else $error("result moved while stalled");
property p_lclsel;
	s_lcl |=> outModel == `DPA_MODEL_LCL;
endproperty
a_lclsel: assert property (p_lclsel) else $error("local model not chosen");
property p_tblsel;
	s_acc ##0 msgBindIdx == `DPA_BTI_LCL && !msgDataCachePort
		&& !msgSecondPort |=> outModel == `DPA_MODEL_TBL;
endproperty
a_tblsel: assert property (p_tblsel) else $error("254 off cache port");
property p_wrap;
	s_lcl ##0 !msgScaled |=> outAddr[15:0] == $past(msgLclBase[15:0]
		+ msgBaseOffset[15:0] + msgLaneOff[15:0]);
endproperty
a_wrap: assert property (p_wrap) else $error("local address not wrapped");
property p_lclmask;
	s_lcl |=> outMask == $past(msgLaneEnable) && !outReject;
endproperty
a_lclmask: assert property (p_lclmask) else $error("local lane masked");
property p_lclcoh;
	s_lcl |=> outCoherency == `DPA_COH_LOCAL;
endproperty
a_lclcoh: assert property (p_lclcoh) else $error("local coherency wrong");
property p_raw;
	s_acc |=> outRawFormat == $past(msgUntyped);
endproperty
a_raw: assert property (p_raw) else $error("raw format flag wrong");
property p_rej;
	outValid && outReject |-> outMask == '0;
endproperty
a_rej: assert property (p_rej) else $error("rejected lanes live");
property p_exc;
	s_acc ##0 msgExcActive && !msgSecondPort && msgBindIdx == `DPA_BTI_HOSTCOH
		|=> outCoherency == `DPA_COH_NONCOH && outL3Virtual;
endproperty
a_exc: assert property (p_exc) else $error("routine access coherent");
property p_gfx;
	s_acc ##0 !msgExcActive && !msgSecondPort && msgBindIdx == `DPA_BTI_GFXCOH
		|=> outCoherency == `DPA_COH_GFX;
endproperty
a_gfx: assert property (p_gfx) else $error("alias 253 coherency wrong");
property p_mask;
	s_acc |=> (outMask & ~$past(msgLaneEnable)) == '0;
endproperty
a_mask: assert property (p_mask) else $error("disabled lane in mask");
endmodule // dpa_bounds_unit_asserts
bind dpa_bounds_unit dpa_bounds_unit_asserts #(.LANES(LANES))
	u_dpa_bounds_unit_asserts (.*);
`default_nettype wire

// File: sim/dpa_thread_model.sv
// Thread side model: offers one message per go pulse
`timescale 1ns/1ps
`default_nettype none
module dpa_thread_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic go,
	input wire logic msgReady,
	output logic msgValid
);
// ==========================================================
// Offer held until taken, as a thread must
always_ff @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
		msgValid <= 1'b0;
	else if (msgValid && msgReady)
		msgValid <= 1'b0;
	else if (go)
		msgValid <= 1'b1;
end
endmodule // dpa_thread_model
`default_nettype wire

// File: sim/dpa_bounds_unit_test.sv
// Self-checking bench for the data port unit
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defines.vh"
module dpa_bounds_unit_test;
// ==========================================================
// Inputs, all given a value at time zero
logic core_clk = 0, arst_n = 0, go = 0, outReady = 0;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0;
logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, msgBindIdx = 0;
logic [31:0] s_axi_wdata = 0, msgBaseOffset = 0, msgBufferBase = 0;
logic [31:0] msgLclBase = 32'h00001000;
logic [3:0] s_axi_wstrb = 4'hF;
logic msgDataCachePort = 0, msgSecondPort = 0, msgSecondStateless = 0;
logic msgW64 = 0, msgHwordScratch = 0, msgExcActive = 0, msgScaled = 0;
logic msgUntyped = 1, surfCoherent = 0;
logic [2:0] msgWidthLog2 = 3'h2, surfType = `DPA_ST_BUFFER;
logic [255:0] msgLaneOff, msgLaneV = 0;
logic [7:0] msgLaneEnable = 8'hFF;
logic [63:0] msgW64Base = 64'h00007FFFFFFFFFF0;
logic [63:0] surfBase = 64'h0000000010000000;
logic [6:0] surfWidth = 7'h0F, surfMocs = 0;
logic [13:0] surfHeight = 0;
logic [10:0] surfDepth = 0, surfPitch = 0;
logic [1:0] surfTileMode = `DPA_TM_LINEAR, pteLlc = 2'h2;
// Outputs
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic s_axi_rvalid, msgReady, msgValid, outValid, outL3Virtual;
logic outRawFormat, outReject;
logic [1:0] s_axi_bresp, s_axi_rresp, outModel, outCoherency;
logic [31:0] s_axi_rdata;
logic [511:0] outAddr;
logic [7:0] outMask;
logic [6:0] outMocs;
int fails = 0, totalChecks = 0;
dpa_bounds_unit u_dpa_bounds_unit (.*);
dpa_thread_model u_dpa_thread_model (.*);
always #10 core_clk = ~core_clk;
// Lane g sits g words past the common offset
initial
	for (int g = 0; g < 8; g++)
		msgLaneOff[g*32+:32] = 4 * g;
// ==========================================================
// Reporting
task automatic giveVerdict;
	$display("checks %0d fails %0d", totalChecks, fails);
	if (fails == 0 && totalChecks > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task automatic chk(input string nm, input logic [63:0] e, g);
	totalChecks++;
	if (g !== e)
	begin
		fails++;
		$display("MISMATCH %s exp %h got %h", nm, e, g);
	end
endtask
// An expired wait is a mismatch
task automatic hang;
	fails++;
	giveVerdict();
endtask
// ==========================================================
// Register bus tasks
task automatic axw(input logic [7:0] a, input logic [31:0] d,
	input logic [1:0] e);
	logic ta, tw, tb;
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1;
	s_axi_wvalid <= 1;
	s_axi_bready <= 1;
	repeat (40)
	begin
		@(negedge core_clk);
		ta = s_axi_awvalid & s_axi_awready;
		tw = s_axi_wvalid & s_axi_wready;
		tb = s_axi_bvalid;
		if (tb) chk("bresp", e, s_axi_bresp);
		@(posedge core_clk);
		if (ta) s_axi_awvalid <= 0;
		if (tw) s_axi_wvalid <= 0;
		if (tb) s_axi_bready <= 0;
		if (tb) return;
	end
	hang();
endtask
task automatic axr(input logic [7:0] a, input logic [31:0] d,
	input logic [1:0] e);
	logic ta, tb;
	s_axi_araddr <= a;
	s_axi_arvalid <= 1;
	s_axi_rready <= 1;
	repeat (40)
	begin
		@(negedge core_clk);
		ta = s_axi_arvalid & s_axi_arready;
		tb = s_axi_rvalid;
		if (tb) chk("rdata", d, s_axi_rdata);
		if (tb) chk("rresp", e, s_axi_rresp);
		@(posedge core_clk);
		if (ta) s_axi_arvalid <= 0;
		if (tb) s_axi_rready <= 0;
		if (tb) return;
	end
	hang();
endtask
// ==========================================================
// Message traffic through the thread model
task automatic launch;
	go <= 1;
	@(posedge core_clk);
	go <= 0;
endtask
task automatic waitOut;
	repeat (40)
	begin
		@(negedge core_clk);
		if (outValid === 1'b1) return;
	end
	hang();
endtask
task automatic releaseOut;
	@(posedge core_clk);
	outReady <= 1;
	@(posedge core_clk);
	outReady <= 0;
endtask
// ==========================================================
// Main sequence
logic [7:0] idx [3] = '{8'hFF, 8'hFD, 8'hFF};
logic [1:0] coh [3] = '{2'h3, 2'h2, 2'h1};
initial
begin
	repeat (12) @(posedge core_clk);
	arst_n <= 1;
	@(posedge core_clk);
	axr(`DPA_REG_CTRL, 0, `DPA_RESP_OKAY);
	axw(`DPA_REG_CTRL, 32'h00000505, `DPA_RESP_OKAY);
	axr(`DPA_REG_CTRL, 32'h00000501, `DPA_RESP_OKAY);
	axw(`DPA_REG_STATUS, 0, `DPA_RESP_SLVERR);
	axr(8'h3C, 0, `DPA_RESP_SLVERR);
	// Local memory offset runs past 64 KB on lanes 4 and up
	msgDataCachePort <= 1;
	msgBindIdx <= `DPA_BTI_LCL;
	msgBaseOffset <= 32'h0000FFF0;
	launch();
	waitOut();
	chk("model", `DPA_MODEL_LCL, outModel);
	chk("coh", `DPA_COH_LOCAL, outCoherency);
	chk("mask", 8'hFF, outMask);
	chk("addr5", 32'h00001004, outAddr[5*64+:32]);
	chk("raw", 1, outRawFormat);
	releaseOut();
	// Same index off the cache port is a surface of 16 bytes
	msgDataCachePort <= 0;
	msgBaseOffset <= 0;
	launch();
	waitOut();
	chk("model", `DPA_MODEL_TBL, outModel);
	chk("mask", 8'h0F, outMask);
	chk("addr1", surfBase + 4, outAddr[64+:64]);
	releaseOut();
	// Wide stateless: lane 4 crosses the canonical boundary
	msgW64 <= 1;
	for (int i = 0; i < 3; i++)
	begin
		msgBindIdx <= idx[i];
		msgExcActive <= (i == 2);
		launch();
		waitOut();
		chk("mask", 8'h0F, outMask);
		chk("addr3", 64'h00007FFFFFFFFFFC, outAddr[3*64+:64]);
		chk("coh", coh[i], outCoherency);
		chk("l3virt", i == 2, outL3Virtual);
		chk("mocs", 7'h06, outMocs);
		releaseOut();
	end
	// Same crossing as a fault: halt, count, restart as bounds miss
	msgExcActive <= 0;
	axw(`DPA_REG_CTRL, 32'h00000503, `DPA_RESP_OKAY);
	launch();
	repeat (4) @(posedge core_clk);
	chk("ready", 0, msgReady);
	axr(`DPA_REG_FAULTS, 1, `DPA_RESP_OKAY);
	axw(`DPA_REG_CTRL, 32'h00000505, `DPA_RESP_OKAY);
	waitOut();
	chk("mask", 8'h0F, outMask);
	releaseOut();
	msgBindIdx <= 8'hF5;
	launch();
	waitOut();
	chk("reject", 1, outReject);
	releaseOut();
	giveVerdict();
end
endmodule // dpa_bounds_unit_test
`default_nettype wire
